// ### core/cies_map.svh
// Register offsets, field positions, error count thresholds and code constants of the interrupt/error block
`ifndef CIES_MAP_SVH
`define CIES_MAP_SVH
`define CIES_OFF_INT        12'h000
`define CIES_OFF_VEC        12'h004
`define CIES_OFF_TREC       12'h008
`define CIES_OFF_CTRL       12'h00C
`define CIES_INT_EN_HI_LSB  27
`define CIES_INT_EN_LO_LSB  16
`define CIES_INT_FL_HI_LSB  11
`define CIES_BIT_SYSERR     12
`define CIES_CTRL_ON_BIT    0
`define CIES_CODE_NONE      7'h40
`define CIES_CODE_BUSERR    7'h41
`define CIES_CODE_WAKE      7'h42
`define CIES_CODE_RXOVF     7'h43
`define CIES_CODE_ADDRERR   7'h44
`define CIES_CODE_BWERR     7'h45
`define CIES_CODE_TMR       7'h46
`define CIES_CODE_MODE      7'h47
`define CIES_CODE_INVALID   7'h48
`define CIES_CNT_WARN       9'h060
`define CIES_CNT_PASSIVE    9'h080
`define CIES_CNT_BUSOFF     9'h100
`endif

// ### core/cies_pkg.sv
// Types shared by the interrupt/error block
package cies_pkg;
    typedef struct packed {
        logic invalid_msg;
        logic wakeup;
        logic bus_error;
        logic addr_error;
        logic bw_error;
        logic rx_overflow;
        logic mode_change;
        logic timer_overflow;
    } cies_events_t;

    typedef struct packed {
        logic [8:0] tx_count;
        logic [7:0] rx_count;
    } cies_errcnt_t;

    typedef enum logic [1:0] {
        CIES_IDLE,
        CIES_WRITE,
        CIES_READ
    } cies_phase_t;
endpackage : cies_pkg

// ### core/cies_top.sv
// AHB-Lite interrupt flag, interrupt code and error state block of a CAN controller
`timescale 1ns/1ns
`include "cies_map.svh"
module cies_top
    import cies_pkg::*;
#(
    parameter int FIFO_COUNT = 32
)
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire cies_events_t          events,
    input  wire logic                  rx_buffer_pending,
    input  wire logic                  tx_buffer_pending,
    input  wire logic [FIFO_COUNT-1:0] fifo_pending_status,
    input  wire logic [4:0]            matched_filter_number,
    input  wire logic                  filter_hit_valid,
    input  wire logic [2:0]            operating_mode_status,
    input  wire logic [2:0]            requested_mode,
    input  wire cies_errcnt_t          error_counts,
    output logic                       irq_request,
    output logic                       module_on
);

    // ************************************************************
    // Bus slave
    // ************************************************************
    cies_phase_t  phase_reg;
    logic [11:0]  addr_reg;
    logic [15:0]  flags_reg;
    logic [4:0]   flag_hi_reg;
    logic [3:0]   flag_lo_reg;
    logic [8:0]   enable_reg;
    logic [6:0]   code_reg;
    logic [4:0]   filter_reg;
    logic [31:0]  trec_reg;
    logic         on_reg;
    logic         on_prev_reg;
    logic         mode_match_reg;
    logic         wr_int;
    logic         wr_ctrl;
    logic [31:0]  int_word;
    logic [31:0]  rd_word;

    // Registered, zero-wait single transfers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_reg <= CIES_IDLE;
            addr_reg  <= 12'h000;
        end
        else if (hready)
        begin
            if (hsel && htrans[1])
            begin
                phase_reg <= hwrite ? CIES_WRITE : CIES_READ;
                addr_reg  <= haddr;
            end
            else
            begin
                phase_reg <= CIES_IDLE;
            end
        end
    end

    assign wr_int  = (phase_reg == CIES_WRITE) && (addr_reg == `CIES_OFF_INT);
    assign wr_ctrl = (phase_reg == CIES_WRITE) && (addr_reg == `CIES_OFF_CTRL);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ************************************************************
    // Flags and enables
    // ************************************************************
    logic [4:0] set_hi;
    logic [1:0] set_lo;
    logic       mode_event;
    assign set_hi = {events.invalid_msg, events.wakeup, events.bus_error,
                     events.addr_error | events.bw_error, events.rx_overflow};
    assign set_lo = {mode_event, events.timer_overflow};

    // Mode change seen as the status newly reaching the request
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Equal at reset is no mode change
            mode_match_reg <= 1'b1;
            on_prev_reg    <= 1'b0;
        end
        else
        begin
            mode_match_reg <= (operating_mode_status == requested_mode);
            on_prev_reg    <= on_reg;
        end
    end

    assign mode_event = (operating_mode_status == requested_mode) && !mode_match_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            enable_reg <= 9'h000;
        else if (wr_int)
            enable_reg <= {hwdata[31:27], hwdata[19:16]};
    end

    // Software clears by writing zero, except the system error flag (bit 12), cleared when on rises,
    // and bits 1:0, which follow the buffer pending inputs; a set in the same cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_hi
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    flag_hi_reg[gi] <= 1'b0;
                else if (set_hi[gi])
                    flag_hi_reg[gi] <= 1'b1;
                else if (`CIES_INT_FL_HI_LSB + gi == `CIES_BIT_SYSERR)
                begin
                    if (on_reg && !on_prev_reg)
                        flag_hi_reg[gi] <= 1'b0;
                end
                else if (wr_int && !hwdata[`CIES_INT_FL_HI_LSB + gi])
                    flag_hi_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_lo_reg <= 4'h0;
        else
        begin
            flag_lo_reg[3] <= set_lo[1] | (flag_lo_reg[3] & ~(wr_int & ~hwdata[3]));
            flag_lo_reg[2] <= set_lo[0] | (flag_lo_reg[2] & ~(wr_int & ~hwdata[2]));
            flag_lo_reg[1:0] <= {rx_buffer_pending, tx_buffer_pending};
        end
    end

    assign flags_reg = {flag_hi_reg, 7'h00, flag_lo_reg};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            on_reg <= 1'b0;
        else if (wr_ctrl)
            on_reg <= hwdata[`CIES_CTRL_ON_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_request <= 1'b0;
            module_on   <= 1'b0;
        end
        else
        begin
            irq_request <= |({flags_reg[15:11], flags_reg[3:0]} & enable_reg);
            module_on   <= on_reg;
        end
    end

    // ************************************************************
    // Interrupt code and filter hit
    // ************************************************************
    function automatic logic [6:0] pick_code(input logic [8:0]  fl,
                                             input logic [8:0]  en,
                                             input logic [FIFO_COUNT-1:0] fifo,
                                             input logic        bw);
        logic [6:0] c;
        c = `CIES_CODE_NONE;
        if (en[8] && fl[8])
            c = `CIES_CODE_INVALID;
        else if (en[7] && fl[7])
            c = `CIES_CODE_WAKE;
        else if (en[6] && fl[6])
            c = `CIES_CODE_BUSERR;
        else if (en[5] && fl[5])
            c = bw ? `CIES_CODE_BWERR : `CIES_CODE_ADDRERR;
        else if (en[4] && fl[4])
            c = `CIES_CODE_RXOVF;
        else if (en[3] && fl[3])
            c = `CIES_CODE_MODE;
        else if (en[2] && fl[2])
            c = `CIES_CODE_TMR;
        else if ((en[1] && fl[1]) || (en[0] && fl[0]))
        begin
            for (int i = FIFO_COUNT - 1; i >= 0; i--)
                if (fifo[i])
                    c = 7'(i);
        end
        return c;
    endfunction : pick_code

    logic bw_seen_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bw_seen_reg <= 1'b0;
        else if (events.bw_error)
            bw_seen_reg <= 1'b1;
        else if (events.addr_error)
            bw_seen_reg <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            code_reg   <= `CIES_CODE_NONE;
            filter_reg <= 5'h00;
        end
        else
        begin
            code_reg <= pick_code({flags_reg[15:11], flags_reg[3:0]},
                                  enable_reg, fifo_pending_status, bw_seen_reg);
            if (filter_hit_valid)
                filter_reg <= matched_filter_number;
        end
    end

    // ************************************************************
    // Error counts and states
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            trec_reg <= 32'h0000_0000;
        else
        begin
            trec_reg[31:22] <= 10'h000;
            trec_reg[21] <= error_counts.tx_count >= `CIES_CNT_BUSOFF;
            trec_reg[20] <= error_counts.tx_count >= `CIES_CNT_PASSIVE;
            trec_reg[19] <= {1'b0, error_counts.rx_count} >= `CIES_CNT_PASSIVE;
            trec_reg[18] <= error_counts.tx_count >= `CIES_CNT_WARN
                            && error_counts.tx_count < `CIES_CNT_PASSIVE;
            trec_reg[17] <= {1'b0, error_counts.rx_count} >= `CIES_CNT_WARN
                            && {1'b0, error_counts.rx_count} < `CIES_CNT_PASSIVE;
            trec_reg[16] <= (error_counts.tx_count >= `CIES_CNT_WARN
                            && error_counts.tx_count < `CIES_CNT_PASSIVE)
                            || ({1'b0, error_counts.rx_count} >= `CIES_CNT_WARN
                            && {1'b0, error_counts.rx_count} < `CIES_CNT_PASSIVE);
            trec_reg[15:8] <= error_counts.tx_count[7:0];
            trec_reg[7:0]  <= error_counts.rx_count;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    assign int_word = {enable_reg[8:4], 7'h00, enable_reg[3:0], flags_reg[15:0]};

    always_comb
    begin
        // Decoded on the address phase, registered into hrdata
        if (haddr == `CIES_OFF_INT)
            rd_word = int_word;
        else if (haddr == `CIES_OFF_VEC)
            rd_word = {19'h0_0000, filter_reg, 1'b0, code_reg};
        else if (haddr == `CIES_OFF_TREC)
            rd_word = trec_reg;
        else if (haddr == `CIES_OFF_CTRL)
            rd_word = {31'h0000_0000, on_reg};
        else
            rd_word = 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            hrdata <= rd_word;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_code_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        !(code_reg inside {[7'h20:7'h3F]}) && code_reg <= `CIES_CODE_INVALID)
        else $error("reserved interrupt code");
    chk_syserr_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        flags_reg[12] && !(on_reg && !on_prev_reg) |=> flags_reg[12])
        else $error("system error flag cleared without on toggle");
    chk_invalid_set: assert property (@(posedge hclk) disable iff (!hresetn)
        events.invalid_msg |=> flags_reg[15])
        else $error("invalid flag not set");
    chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (enable_reg == 9'h000) |=> !irq_request)
        else $error("request without enable");
    chk_busoff_state: assert property (@(posedge hclk) disable iff (!hresetn)
        error_counts.tx_count >= `CIES_CNT_BUSOFF |=> trec_reg[21] && trec_reg[20])
        else $error("bus off not reported");
    chk_rx_warn: assert property (@(posedge hclk) disable iff (!hresetn)
        error_counts.rx_count == 8'h60 |=> trec_reg[17] && trec_reg[16])
        else $error("rx warning missing");
    chk_disabled_code: assert property (@(posedge hclk) disable iff (!hresetn)
        enable_reg == 9'h000 |=> code_reg == `CIES_CODE_NONE)
        else $error("code from disabled source");
    chk_mode_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_event |=> flags_reg[3])
        else $error("mode flag not set");
    cov_syserr_clear: cover property (@(posedge hclk) flags_reg[12] ##1 !flags_reg[12]);
    cov_invalid_code: cover property (@(posedge hclk) code_reg == `CIES_CODE_INVALID);
    cov_busoff: cover property (@(posedge hclk) trec_reg[21]);

endmodule : cies_top

// ### bench/cies_far_model.sv
// Far-side model: the CAN core's event, status and counter sources
`timescale 1ns/1ns
module cies_far_model
    import cies_pkg::*;
(
    input  wire logic   hclk,
    output cies_events_t events,
    output logic        rx_buffer_pending,
    output logic        tx_buffer_pending,
    output logic [31:0] fifo_pending_status,
    output logic [4:0]  matched_filter_number,
    output logic        filter_hit_valid,
    output logic [2:0]  operating_mode_status,
    output logic [2:0]  requested_mode,
    output cies_errcnt_t error_counts
);
    initial
    begin
        events = '0;
        rx_buffer_pending = 1'b0;
        tx_buffer_pending = 1'b0;
        fifo_pending_status = 32'h0000_0000;
        matched_filter_number = 5'h00;
        filter_hit_valid = 1'b0;
        operating_mode_status = 3'h0;
        requested_mode = 3'h0;
        error_counts = '0;
    end

    task automatic pulse(input cies_events_t e);
        @(posedge hclk);
        events <= e;
        @(posedge hclk);
        events <= '0;
    endtask : pulse

    task automatic levels(input logic rxp, input logic txp, input logic [31:0] fifo);
        @(posedge hclk);
        rx_buffer_pending <= rxp;
        tx_buffer_pending <= txp;
        fifo_pending_status <= fifo;
    endtask : levels

    // Status follows the request a little later, as a real mode switch does
    task automatic change_mode(input logic [2:0] m);
        @(posedge hclk);
        requested_mode <= m;
        repeat (2) @(posedge hclk);
        operating_mode_status <= m;
    endtask : change_mode

    // Number is only meaningful with the strobe; scrambled afterwards
    task automatic hit(input logic [4:0] n);
        @(posedge hclk);
        matched_filter_number <= n;
        filter_hit_valid <= 1'b1;
        @(posedge hclk);
        matched_filter_number <= ~n;
        filter_hit_valid <= 1'b0;
    endtask : hit

    task automatic counts(input logic [8:0] t, input logic [7:0] r);
        @(posedge hclk);
        error_counts <= '{tx_count: t, rx_count: r};
    endtask : counts
endmodule : cies_far_model

// ### bench/tb_top.sv
// Self-checking bench of the interrupt flag, code and error state block
`timescale 1ns/1ns
`include "cies_map.svh"
module tb_top
    import cies_pkg::*;
;
    typedef struct packed {
        cies_events_t ev;
        logic         mode;
        logic         rxp;
        logic         txp;
        logic [31:0]  fifo;
        logic [31:0]  flag;
        logic [6:0]   code;
    } cies_row_t;

    localparam logic [31:0] en_all = 32'hF80F_0000;
    logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_request, module_on;
    logic [11:0]  haddr;
    logic [1:0]   htrans;
    logic [2:0]   hsize, operating_mode_status, requested_mode;
    logic [31:0]  hwdata, hrdata, rd, xp, fifo_pending_status;
    logic         rx_buffer_pending, tx_buffer_pending, filter_hit_valid;
    logic [4:0]   matched_filter_number;
    cies_events_t events;
    cies_errcnt_t error_counts;
    int           miscompares, compares, i;
    cies_row_t    rows [10] = '{
        '{8'h80, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_8000, 7'h48},
        '{8'h40, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_4000, 7'h42},
        '{8'h20, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_2000, 7'h41},
        '{8'h10, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_1000, 7'h44},
        '{8'h08, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_1000, 7'h45},
        '{8'h04, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0800, 7'h43},
        '{8'h00, 1'b1, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0008, 7'h47},
        '{8'h01, 1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0004, 7'h46},
        '{8'h00, 1'b0, 1'b1, 1'b0, 32'h8000_0000, 32'h0000_0002, 7'h1F},
        '{8'h00, 1'b0, 1'b0, 1'b1, 32'h0000_0001, 32'h0000_0001, 7'h00}};
    logic [8:0]   tx_tab [7] = '{9'h000, 9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};
    logic [7:0]   rx_tab [7] = '{8'h00, 8'h60, 8'h5F, 8'h80, 8'h7F, 8'hFF, 8'h61};

    cies_top #(.FIFO_COUNT(32)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .events(events),
        .rx_buffer_pending(rx_buffer_pending), .tx_buffer_pending(tx_buffer_pending),
        .fifo_pending_status(fifo_pending_status), .matched_filter_number(matched_filter_number),
        .filter_hit_valid(filter_hit_valid), .operating_mode_status(operating_mode_status),
        .requested_mode(requested_mode), .error_counts(error_counts),
        .irq_request(irq_request), .module_on(module_on));

    cies_far_model u_far (
        .hclk(hclk), .events(events), .rx_buffer_pending(rx_buffer_pending),
        .tx_buffer_pending(tx_buffer_pending), .fifo_pending_status(fifo_pending_status),
        .matched_filter_number(matched_filter_number), .filter_hit_valid(filter_hit_valid),
        .operating_mode_status(operating_mode_status), .requested_mode(requested_mode),
        .error_counts(error_counts));

    always #10 hclk = ~hclk;

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    function automatic logic [31:0] exp_trec(input logic [8:0] t, input logic [7:0] r);
        logic tw;
        logic rw;
        tw = (t >= 9'h060) && (t < 9'h080);
        rw = (r >= 8'h60) && (r < 8'h80);
        return {10'h000, t >= 9'h100, t >= 9'h080, r >= 8'h80, tw, rw, tw | rw, t[7:0], r};
    endfunction : exp_trec

    task automatic print_verdict();
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        print_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        miscompares = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(`CIES_OFF_INT, 1'b0, 32'h0);
        check_word("int reset", 32'h0000_0000, rd);
        ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
        check_word("vec reset", 32'h0000_0040, rd);
        check_bit("resp", 1'b0, hresp);
        check_bit("ready", 1'b1, hreadyout);
        ahb(`CIES_OFF_CTRL, 1'b1, 32'h0000_0001);
        ahb(`CIES_OFF_INT, 1'b1, en_all);
        check_bit("on", 1'b1, module_on);
        for (i = 0; i < 10; i++)
        begin
            u_far.levels(rows[i].rxp, rows[i].txp, rows[i].fifo);
            if (rows[i].ev !== '0)
                u_far.pulse(rows[i].ev);
            if (rows[i].mode)
                u_far.change_mode(3'b100);
            repeat (3) @(posedge hclk);
            ahb(`CIES_OFF_INT, 1'b0, 32'h0);
            xp = en_all | rows[i].flag;
            check_word("int flags", xp, rd);
            ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
            check_word("vector", {25'h0, rows[i].code}, rd);
            check_bit("irq", 1'b1, irq_request);
            u_far.levels(1'b0, 1'b0, 32'h0);
            repeat (2) @(posedge hclk);
            ahb(`CIES_OFF_INT, 1'b1, en_all);
            ahb(`CIES_OFF_INT, 1'b0, 32'h0);
            check_word("int cleared", en_all | (rows[i].flag & 32'h0000_1000), rd);
            if (rows[i].flag[12])
            begin
                ahb(`CIES_OFF_CTRL, 1'b1, 32'h0);
                ahb(`CIES_OFF_CTRL, 1'b1, 32'h0000_0001);
            end
        end
        // Pending but disabled source must not steer the code or the request
        ahb(`CIES_OFF_INT, 1'b1, 32'h0);
        u_far.pulse(8'h20);
        repeat (3) @(posedge hclk);
        ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
        check_word("vec disabled", 32'h0000_0040, rd);
        check_bit("irq disabled", 1'b0, irq_request);
        ahb(`CIES_OFF_INT, 1'b1, 32'h2000_2000);
        repeat (3) @(posedge hclk);
        ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
        check_word("vec enabled", 32'h0000_0041, rd);
        // Two sources at once, then writes to read-only and unmapped places
        ahb(`CIES_OFF_INT, 1'b1, en_all);
        u_far.pulse(8'h81);
        repeat (3) @(posedge hclk);
        ahb(`CIES_OFF_VEC, 1'b1, 32'hFFFF_FFFF);
        ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
        check_word("vec both", 32'h0000_0048, rd);
        ahb(12'h010, 1'b1, 32'hFFFF_FFFF);
        ahb(12'h010, 1'b0, 32'h0);
        check_word("unmapped", 32'h0000_0000, rd);
        ahb(`CIES_OFF_INT, 1'b1, en_all);
        for (i = 0; i < 7; i++)
        begin
            u_far.counts(tx_tab[i], rx_tab[i]);
            repeat (3) @(posedge hclk);
            ahb(`CIES_OFF_TREC, 1'b1, 32'hFFFF_FFFF);
            ahb(`CIES_OFF_TREC, 1'b0, 32'h0);
            xp = exp_trec(tx_tab[i], rx_tab[i]);
            check_word("errcount", xp, rd);
        end
        u_far.hit(5'h1F);
        repeat (3) @(posedge hclk);
        ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
        check_word("filter hit", 32'h0000_1F40, rd);
        // Reset in mid-run: vector back to idle code, filter number cleared
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_bit("on after reset", 1'b0, module_on);
        ahb(`CIES_OFF_VEC, 1'b0, 32'h0);
        check_word("vec mid reset", 32'h0000_0040, rd);
        print_verdict();
    end
endmodule : tb_top
